// ==== hw/ddrcm_core.sv ====
// ddr2 device command side: decode, banks, posted access, bursts, config word
// assumes the controller drives pins synchronously to ref_clk, one data beat per clock
`timescale 1ns/1ns
`default_nettype none

// Functional notes
// (R01) write: bank, start column, A10 autoprecharge
// (R02) posted access delayed by additive latency
// (R03) byte lane written only when mask low
// (R04) precharge closes bank, idle after delay
// (R05) repeated precharge restarts precharge period
// (R06) refresh uses internal row, ignores address
// (R07) self refresh on refresh with enable low
// (R08) config word kept, dll restart self-clears
// (R09) controller loads config only when idle
// (R10) burst size four or eight columns
// (R11) burst wraps inside aligned column block
// (R12) sequential nibble wrap or interleaved xor order
// (R13) vendor test bit blocks other updates
// (R14) dll restart needs 200 clocks before read
// (R15) write autoprecharge waits recovery count
// (R16) controller rounds recovery count up
// (R17) powerdown exit style fast or slow
// (R18) read delay whole clocks three to seven
// (R19) read data at edge n plus m
// (R20) controller writes zero above bit 12
// (R21) bank inputs select the config register
// (R22) write latency is read latency minus one
// (R23) commands taken with select low, enable high
module ddrcm_core
  import ddrcm_pkg::*;
#(
  parameter int BANKS  = 4,
  parameter int ROW_W  = 2,
  parameter int COL_W  = 4,
  parameter int ADDR_W = 14,
  parameter int LANES  = 2
) (
  input  wire logic                 ref_clk,        // command clock
  input  wire logic                 resetn,         // async reset, low active
  input  wire logic                 cke,            // clock enable pin
  input  wire logic                 cs_n,           // chip select, low active
  input  wire logic                 ras_n,          // row strobe, low active
  input  wire logic                 cas_n,          // column strobe, low active
  input  wire logic                 we_n,           // write enable, low active
  input  wire logic [2:0]           ba,             // bank address
  input  wire logic [ADDR_W-1:0]    addr,           // address pins
  input  wire logic [2:0]           additive_lat,   // additive latency 0..6
  input  wire logic [LANES*8-1:0]   dq_in,          // write data beat
  input  wire logic [LANES-1:0]     dm,             // data mask, high skips lane
  output logic      [LANES*8-1:0]   dq_out,         // read data beat
  output logic                      dq_oe,          // read data valid
  output logic      [CFG_W-1:0]     cfg_word,       // stored config word
  output logic      [BANKS-1:0]     bank_open,      // row open per bank
  output logic      [BANKS-1:0]     bank_idle,      // idle per bank
  output logic      [ROW_W-1:0]     refresh_row,    // next internal refresh row
  output logic                      self_refresh,   // in self refresh
  output logic                      dll_ready,      // dll running and settled
  output logic                      dll_frozen,     // slow-exit powerdown active
  output logic                      test_mode       // vendor test selected
);
  import ddrcm_pkg::*;

  localparam int BANK_W = $clog2(BANKS);
  localparam int DEPTH  = BANKS << (ROW_W + COL_W);
  localparam int MEM_AW = BANK_W + ROW_W + COL_W;

  // ----------------------------------------------------------------
  // storage and state
  // ----------------------------------------------------------------
  logic [BANKS-1:0]   idle_out_reg;
  logic [CFG_W-1:0]   cfg_reg;
  logic               test_reg;
  logic               sr_reg;
  logic               pd_reg;
  logic               dll_ready_reg;
  logic [CNT_W-1:0]   dll_cnt_reg;
  logic [ROW_W-1:0]   ref_row_reg;
  logic [BANKS-1:0]   open_reg;
  logic [ROW_W-1:0]   row_reg [BANKS];
  logic [CNT_W-1:0]   pre_cnt_reg [BANKS];
  ddrcm_state_t       state_reg;
  logic [CNT_W-1:0]   lat_cnt_reg;
  logic [2:0]         beat_reg;
  logic               acc_wr_reg;
  logic               acc_ap_reg;
  logic [BANK_W-1:0]  acc_bank_reg;
  logic [COL_W-1:0]   acc_col_reg;
  logic [CNT_W-1:0]   rec_cnt_reg;
  logic [BANK_W-1:0]  rec_bank_reg;
  logic [LANES*8-1:0] dq_out_reg;
  logic               dq_oe_reg;

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  wire ddrcm_cmd_t cmd      = ddrcm_cmd_t'({ras_n, cas_n, we_n});
  wire             sel      = !cs_n;
  wire             take     = sel && cke && !sr_reg; // R23
  wire             is_load  = take && cmd == DDRCM_CMD_LOAD;
  wire             is_ref   = take && cmd == DDRCM_CMD_REF;
  wire             is_pre   = take && cmd == DDRCM_CMD_PRE;
  wire             is_act   = take && cmd == DDRCM_CMD_ACT;
  wire             is_acc   = take && (cmd == DDRCM_CMD_READ || cmd == DDRCM_CMD_WRITE);
  wire             sr_enter = sel && !cke && !sr_reg && cmd == DDRCM_CMD_REF; // R07
  wire             sr_exit  = sr_reg && cke;
  wire [BANK_W-1:0] cmd_bank = ba[BANK_W-1:0];
  wire             ap_bit   = addr[10];                       // R01
  wire             cfg_sel  = is_load && ba == CFG_SELECT_BA; // R21

  // ----------------------------------------------------------------
  // config fields and latencies
  // ----------------------------------------------------------------
  wire             bl8      = cfg_reg[BURST_SIZE_LSB +: 3] == BURST_SIZE_8; // R10
  wire             ilv      = cfg_reg[BURST_ORDER_BIT];
  wire [2:0]       cl_code  = cfg_reg[READ_DELAY_LSB +: 3];                 // R18
  wire [2:0]       wr_code  = cfg_reg[RECOVERY_LSB +: 3];
  wire             slow_pd  = cfg_reg[PD_EXIT_STYLE_BIT];                   // R17
  wire [CNT_W-1:0] rl       = CNT_W'(additive_lat) + CNT_W'(cl_code);       // R02 R19
  wire [CNT_W-1:0] wl       = rl - CNT_W'(1);                               // R22
  wire [CNT_W-1:0] wr_clks  = CNT_W'(wr_code) + CNT_W'(1);                  // R15
  wire [2:0]       last_bt  = bl8 ? 3'h7 : 3'h3;

  // burst column for the current beat; block bits above the burst stay fixed
  function automatic logic [COL_W-1:0] burst_col(input logic [COL_W-1:0] start,
                                                 input logic [2:0] idx,
                                                 input logic is8,
                                                 input logic il);
    logic [COL_W-1:0] c;
    logic [1:0]       low;
    c   = start;
    low = il ? (start[1:0] ^ idx[1:0]) : (start[1:0] + idx[1:0]); // R12
    c[1:0] = low;                                                  // R11
    if (is8) begin
      c[2] = start[2] ^ idx[2];                                    // R11 R12
    end
    return c;
  endfunction

  wire [COL_W-1:0]  cur_col = burst_col(acc_col_reg, beat_reg, bl8, ilv);
  wire [MEM_AW-1:0] cur_adr = {acc_bank_reg, row_reg[acc_bank_reg], cur_col};
  wire              in_data = state_reg == DDRCM_DATA;
  wire              burst_end = in_data && beat_reg == last_bt;
  wire              rec_done  = rec_cnt_reg == CNT_W'(1);
  wire              rd_ap_end = burst_end && !acc_wr_reg && acc_ap_reg;
  wire [BANKS-1:0]  bank_idle_w;
  wire              all_idle  = &bank_idle_w;
  wire [COL_W-1:0]  nxt_col   = burst_col(acc_col_reg, beat_reg + 3'h1, bl8, ilv);
  wire [MEM_AW-1:0] rd_adr    = {acc_bank_reg, row_reg[acc_bank_reg],
                                 in_data ? nxt_col : acc_col_reg};
  wire [LANES*8-1:0] rd_word;

  // ----------------------------------------------------------------
  // per-bank row and precharge state
  // ----------------------------------------------------------------
  genvar b;
  generate
    for (b = 0; b < BANKS; b++) begin : g_bank
      wire hit     = cmd_bank == BANK_W'(b);
      wire pre_cmd = is_pre && (ap_bit || hit);               // R04
      wire pre_ap  = (rd_ap_end && acc_bank_reg == BANK_W'(b))
                     || (rec_done && rec_bank_reg == BANK_W'(b)); // R15
      assign bank_idle_w[b] = !open_reg[b] && pre_cnt_reg[b] == '0;
      always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
          open_reg[b]    <= 1'b0;
          row_reg[b]     <= '0;
          pre_cnt_reg[b] <= '0;
        end else if (pre_cmd || pre_ap) begin
          open_reg[b]    <= 1'b0;
          pre_cnt_reg[b] <= CNT_W'(PRECHARGE_CYC); // R05
        end else if (is_act && hit && bank_idle_w[b]) begin
          open_reg[b]    <= 1'b1;
          row_reg[b]     <= addr[ROW_W-1:0];
        end else if (pre_cnt_reg[b] != '0) begin
          pre_cnt_reg[b] <= pre_cnt_reg[b] - CNT_W'(1);
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // config word, dll, refresh, power states
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cfg_reg  <= CFG_RESET;
      test_reg <= 1'b0;
    end else if (cfg_sel && all_idle) begin
      if (addr[VENDOR_TEST_BIT]) begin
        test_reg <= 1'b1; // R13
      end else begin
        test_reg <= 1'b0;
        cfg_reg  <= CFG_W'(addr) & ~(CFG_W'(1) << DLL_RESTART_BIT); // R08
      end
    end
  end

  // dll restarts on the restart bit and on self refresh exit
  wire dll_restart = (cfg_sel && all_idle && !addr[VENDOR_TEST_BIT] && addr[DLL_RESTART_BIT])
                     || sr_exit; // R14 R07
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      dll_cnt_reg   <= '0;
      dll_ready_reg <= 1'b0;
    end else if (sr_enter && all_idle) begin
      dll_cnt_reg   <= '0;
      dll_ready_reg <= 1'b0; // R07
    end else if (dll_restart) begin
      dll_cnt_reg   <= CNT_W'(DLL_LOCK_CYC);
      dll_ready_reg <= 1'b0;
    end else if (dll_cnt_reg != '0) begin
      dll_cnt_reg   <= dll_cnt_reg - CNT_W'(1);
      dll_ready_reg <= dll_cnt_reg == CNT_W'(1); // R14
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sr_reg      <= 1'b0;
      pd_reg      <= 1'b0;
      ref_row_reg <= '0;
      idle_out_reg <= '0;
    end else begin
      if (sr_enter && all_idle) begin
        sr_reg <= 1'b1;
      end else if (sr_exit) begin
        sr_reg <= 1'b0;
      end
      pd_reg       <= !cke && !sr_reg && |open_reg && slow_pd; // slow-exit active powerdown
      idle_out_reg <= bank_idle_w;
      if ((is_ref && all_idle) || sr_reg) begin
        ref_row_reg <= ref_row_reg + ROW_W'(1); // R06
      end
    end
  end

  // ----------------------------------------------------------------
  // posted access and burst engine; one access in flight, others dropped
  // ----------------------------------------------------------------
  wire start_ok = is_acc && state_reg == DDRCM_IDLE && open_reg[cmd_bank]; // R04
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg    <= DDRCM_IDLE;
      lat_cnt_reg  <= '0;
      beat_reg     <= 3'h0;
      acc_wr_reg   <= 1'b0;
      acc_ap_reg   <= 1'b0;
      acc_bank_reg <= '0;
      acc_col_reg  <= '0;
    end else begin
      unique case (state_reg)
        DDRCM_IDLE: begin
          if (start_ok) begin
            acc_wr_reg   <= !we_n;
            acc_ap_reg   <= ap_bit;               // R01
            acc_bank_reg <= cmd_bank;
            acc_col_reg  <= addr[COL_W-1:0];
            lat_cnt_reg  <= (!we_n ? wl : rl) - CNT_W'(1); // R02 R22
            state_reg    <= DDRCM_WAIT;
          end
        end
        DDRCM_WAIT: begin
          if (lat_cnt_reg == CNT_W'(1)) begin
            state_reg <= DDRCM_DATA; // R19
            beat_reg  <= 3'h0;
          end else begin
            lat_cnt_reg <= lat_cnt_reg - CNT_W'(1);
          end
        end
        DDRCM_DATA: begin
          if (beat_reg == last_bt) begin
            state_reg <= DDRCM_IDLE;
          end
          beat_reg <= beat_reg + 3'h1;
        end
      endcase
    end
  end

  // write recovery before the internal precharge of an autoprecharge write
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rec_cnt_reg  <= '0;
      rec_bank_reg <= '0;
    end else if (burst_end && acc_wr_reg && acc_ap_reg) begin
      rec_cnt_reg  <= wr_clks; // R15
      rec_bank_reg <= acc_bank_reg;
    end else if (rec_cnt_reg != '0) begin
      rec_cnt_reg  <= rec_cnt_reg - CNT_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // array access: byte lanes written under the mask
  // ----------------------------------------------------------------
  genvar l;
  generate
    for (l = 0; l < LANES; l++) begin : g_lane
      logic [7:0] lane_mem [DEPTH];
      always_ff @(posedge ref_clk) begin
        if (in_data && acc_wr_reg && !dm[l]) begin
          lane_mem[cur_adr] <= dq_in[l*8 +: 8]; // R03
        end
      end
      assign rd_word[l*8 +: 8] = lane_mem[rd_adr];
    end
  endgenerate

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      dq_out_reg <= '0;
      dq_oe_reg  <= 1'b0;
    end else begin
      dq_oe_reg  <= (state_reg == DDRCM_WAIT && lat_cnt_reg == CNT_W'(1) && !acc_wr_reg)
                    || (in_data && !acc_wr_reg && !burst_end);
      dq_out_reg <= rd_word;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign dq_out       = dq_out_reg;
  assign dq_oe        = dq_oe_reg;
  assign cfg_word     = cfg_reg;
  assign bank_open    = open_reg;
  assign bank_idle    = idle_out_reg;
  assign refresh_row  = ref_row_reg;
  assign self_refresh = sr_reg;
  assign dll_ready    = dll_ready_reg;
  assign dll_frozen   = pd_reg;
  assign test_mode    = test_reg;
endmodule

`default_nettype wire

// ==== shared/ddrcm_pkg.sv ====
// shared constants for the ddr2 command and mode logic
// assumes one command clock at 100 MHz drives every register
package ddrcm_pkg;
  // ----------------------------------------------------------------
  // operating_config_word field positions
  // ----------------------------------------------------------------
  localparam int CFG_W              = 17;
  localparam int BURST_SIZE_LSB     = 0;
  localparam int BURST_ORDER_BIT    = 3;
  localparam int READ_DELAY_LSB     = 4;
  localparam int VENDOR_TEST_BIT    = 7;
  localparam int DLL_RESTART_BIT    = 8;
  localparam int RECOVERY_LSB       = 9;
  localparam int PD_EXIT_STYLE_BIT  = 12;
  localparam logic [CFG_W-1:0] CFG_RESET = 17'h00000;
  localparam logic [2:0] BURST_SIZE_8   = 3'h3;
  localparam logic [2:0] CFG_SELECT_BA  = 3'h0;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS      = 10000;
  localparam int PRECHARGE_TIME_PS  = 15000;
  localparam int PRECHARGE_CYC      = (PRECHARGE_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int DLL_LOCK_CYC       = 200;
  localparam int CNT_W              = 8;

  // ----------------------------------------------------------------
  // commands as {ras_n, cas_n, we_n}
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    DDRCM_CMD_LOAD  = 3'h0,
    DDRCM_CMD_REF   = 3'h1,
    DDRCM_CMD_PRE   = 3'h2,
    DDRCM_CMD_ACT   = 3'h3,
    DDRCM_CMD_WRITE = 3'h4,
    DDRCM_CMD_READ  = 3'h5,
    DDRCM_CMD_BST   = 3'h6,
    DDRCM_CMD_NOP   = 3'h7
  } ddrcm_cmd_t;

  typedef enum logic [1:0] {
    DDRCM_IDLE,
    DDRCM_WAIT,
    DDRCM_DATA
  } ddrcm_state_t;
endpackage

// ==== testbench/ddrcm_core_assertions.sv ====
// checker for the ddr2 command core, bound to its ports
// assumes every pin is synchronous to ref_clk
`timescale 1ns/1ns
`default_nettype none
module ddrcm_core_checker
  import ddrcm_pkg::*;
#(
  parameter int BANKS  = 4,
  parameter int ROW_W  = 2,
  parameter int ADDR_W = 14
) (
  input wire logic              ref_clk,      // clock
  input wire logic              resetn,       // reset
  input wire logic              cke,          // clock enable
  input wire logic              cs_n,         // select
  input wire logic              ras_n,        // row strobe
  input wire logic              cas_n,        // column strobe
  input wire logic              we_n,         // write enable
  input wire logic [2:0]        ba,           // bank
  input wire logic [ADDR_W-1:0] addr,         // address
  input wire logic [2:0]        additive_lat, // posted delay
  input wire logic              dq_oe,        // read valid
  input wire logic [CFG_W-1:0]  cfg_word,     // config
  input wire logic [BANKS-1:0]  bank_idle,    // idle banks
  input wire logic [ROW_W-1:0]  refresh_row,  // refresh row
  input wire logic              self_refresh, // self refresh
  input wire logic              dll_ready,    // dll settled
  input wire logic              test_mode     // vendor test
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  wire logic [2:0] cmd = {ras_n, cas_n, we_n};
  wire logic       sel = !cs_n && !self_refresh;
  wire logic       go  = sel && cke && &bank_idle;
  wire logic       rd  = sel && cke && cmd == DDRCM_CMD_READ;
  wire logic       ld  = go && cmd == DDRCM_CMD_LOAD && ba == 3'h0;
  // cycles since the dll last had to restart
  logic [8:0] since;
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      since <= 9'h000;
    end else if ((ld && addr[8] && !addr[7]) || self_refresh) begin
      since <= 9'h000;
    end else if (since != 9'h1FF) begin
      since <= since + 9'h001;
    end
  end
  sequence burst4; dq_oe [*4] ##1 !dq_oe; endsequence
  sequence burst8; dq_oe [*8] ##1 !dq_oe; endsequence
  a_bl4_len: assert property ($rose(dq_oe) && cfg_word[2:0] != BURST_SIZE_8 |-> burst4)
    else $error("short burst has wrong length");
  a_bl8_len: assert property ($rose(dq_oe) && cfg_word[2:0] == BURST_SIZE_8 |-> burst8)
    else $error("long burst has wrong length");
  a_read_lat: assert property ($rose(dq_oe) && additive_lat == 3'h0 && cfg_word[6:4] == 3'h3
      |-> $past(rd, 3))
    else $error("read data not three clocks after read");
  a_dll_wait: assert property ($rose(dll_ready) |-> since >= 9'h0C7)
    else $error("dll ready too early");
  a_cfg_load: assert property (ld && !addr[7] |=> cfg_word == {3'h0, $past(addr) & 14'h3EFF})
    else $error("config word not stored");
  a_vendor_hold: assert property (ld && addr[7] |=> $stable(cfg_word) && test_mode)
    else $error("vendor load changed config");
  a_other_reg: assert property (go && cmd == DDRCM_CMD_LOAD && ba != 3'h0 |=> $stable(cfg_word))
    else $error("foreign register load changed config");
  a_refresh_step: assert property (go && cmd == DDRCM_CMD_REF
      |=> refresh_row == ROW_W'($past(refresh_row) + 1'b1))
    else $error("refresh row did not advance");
  a_sr_enter: assert property (!cs_n && !cke && !self_refresh && cmd == DDRCM_CMD_REF && &bank_idle
      |=> self_refresh ##1 !dll_ready)
    else $error("self refresh entry wrong");
endmodule
bind ddrcm_core ddrcm_core_checker #(.BANKS(BANKS), .ROW_W(ROW_W), .ADDR_W(ADDR_W)) u_chk (
  .ref_clk(ref_clk), .resetn(resetn), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n),
  .we_n(we_n), .ba(ba), .addr(addr), .additive_lat(additive_lat), .dq_oe(dq_oe),
  .cfg_word(cfg_word), .bank_idle(bank_idle), .refresh_row(refresh_row),
  .self_refresh(self_refresh), .dll_ready(dll_ready), .test_mode(test_mode));
`default_nettype wire

// ==== testbench/ddrcm_ctrl_model.sv ====
// controller side model: command, address, mask and data pins
// assumes the bench calls its tasks one at a time
`timescale 1ns/1ns
`default_nettype none
module ddrcm_ctrl_model
  import ddrcm_pkg::*;
#(
  parameter int SETTLE = 2  // config_settle_time in clocks
) (
  input  wire logic        ref_clk, // clock
  output var  logic        cke,     // clock enable
  output var  logic        cs_n,    // select
  output var  logic        ras_n,   // row strobe
  output var  logic        cas_n,   // column strobe
  output var  logic        we_n,    // write enable
  output var  logic [2:0]  ba,      // bank
  output var  logic [13:0] addr,    // address
  output var  logic [15:0] dq_in,   // write beat
  output var  logic [1:0]  dm       // lane mask
);
  initial begin
    {cke, cs_n, ras_n, cas_n, we_n} = 5'h17;
    ba = 3'h0;
    addr = 14'h0000;
    dq_in = 16'h0000;
    dm = 2'h3;
  end
  task automatic clk_en(input logic v);
    @(posedge ref_clk);
    cke <= v;
  endtask
  task automatic desel(input logic v);
    @(posedge ref_clk);
    cs_n <= v;
  endtask
  task automatic cmd(input ddrcm_cmd_t c, input logic [2:0] b, input logic [13:0] a);
    @(posedge ref_clk);
    {ras_n, cas_n, we_n} <= c;
    ba <= b;
    addr <= a;
    @(posedge ref_clk);
    {ras_n, cas_n, we_n} <= DDRCM_CMD_NOP;
    addr <= ~a; // released lines must not keep the last value
    if (c == DDRCM_CMD_LOAD) repeat (SETTLE) @(posedge ref_clk);
  endtask
  task automatic wdata(input int wl, input logic [15:0] base, input logic [15:0] mk, input int n);
    repeat (wl - 1) @(posedge ref_clk);
    for (int i = 0; i < n; i++) begin
      dq_in <= base + 16'(i) * 16'h0101;
      dm <= mk[2*i +: 2];
      @(posedge ref_clk);
    end
    dq_in <= ~dq_in;
    dm <= ~dm;
  endtask
endmodule
`default_nettype wire

// ==== testbench/ddrcm_core_tb_top.sv ====
// self-checking bench for the ddr2 command core
// assumes the checker is bound and the model drives the command, address, mask and data pins
`timescale 1ns/1ns
`default_nettype none
module ddrcm_core_tb_top;
  import ddrcm_pkg::*;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic [2:0] additive_lat = 3'h0;
  logic cke, cs_n, ras_n, cas_n, we_n, dq_oe, self_refresh, dll_ready, dll_frozen, test_mode;
  logic [2:0] ba;
  logic [13:0] addr;
  logic [15:0] dq_in, dq_out;
  logic [1:0] dm, refresh_row;
  logic [16:0] cfg_word;
  logic [3:0] bank_open, bank_idle;
  int error_cnt = 0;
  int cmp_count = 0;
  always #5 ref_clk = ~ref_clk;
  ddrcm_ctrl_model ctl (.ref_clk(ref_clk), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .dq_in(dq_in), .dm(dm));
  ddrcm_core dut (.ref_clk(ref_clk), .resetn(resetn), .cke(cke), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .additive_lat(additive_lat),
    .dq_in(dq_in), .dm(dm), .dq_out(dq_out), .dq_oe(dq_oe), .cfg_word(cfg_word),
    .bank_open(bank_open), .bank_idle(bank_idle), .refresh_row(refresh_row),
    .self_refresh(self_refresh), .dll_ready(dll_ready), .dll_frozen(dll_frozen),
    .test_mode(test_mode));
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic bail();
    error_cnt++;
    $display("BAD %0t wait ran out", $time);
    complete_run();
  endtask
  task automatic wait_dll(output int n);
    for (n = 0; n < 300 && dll_ready !== 1'b1; n++) @(negedge ref_clk);
    if (n == 300) bail();
  endtask
  task automatic wait_idle(input int b);
    int n;
    for (n = 0; n < 20 && bank_idle[b] !== 1'b1; n++) @(negedge ref_clk);
    if (n == 20) bail();
  endtask
  // pd style fast, reserved bits zero
  function automatic logic [13:0] cfg(input logic [2:0] bl, input logic bt, input logic [2:0] cl,
      input logic dll, input logic [2:0] wr);
    return {2'b00, wr, dll, 1'b0, cl, bt, bl};
  endfunction
  task automatic rd(input logic [2:0] b, input logic [13:0] a, input int lat, input int n,
      input logic [15:0] e[8]);
    ctl.cmd(DDRCM_CMD_READ, b, a);
    repeat (lat - 1) @(posedge ref_clk);
    for (int i = 0; i < n; i++) begin
      @(negedge ref_clk);
      check({dq_oe, dq_out}, {1'b1, e[i]});
      @(posedge ref_clk);
    end
    @(negedge ref_clk);
    check(dq_oe, 1'b0);
  endtask
  task automatic t_config();
    logic [13:0] a;
    int n;
    a = cfg(3'h2, 1'b0, 3'h3, 1'b1, 3'h1);
    ctl.cmd(DDRCM_CMD_LOAD, 3'h0, a);
    @(negedge ref_clk);
    check(cfg_word, {3'h0, a & 14'h3EFF});
    check(dll_ready, 1'b0);
    wait_dll(n);
    check(n >= 190, 1'b1);
    ctl.cmd(DDRCM_CMD_LOAD, 3'h0, 14'h0FFF);
    @(negedge ref_clk);
    check({test_mode, dll_ready, cfg_word}, {2'b11, 3'h0, a & 14'h3EFF});
    ctl.cmd(DDRCM_CMD_LOAD, 3'h1, 14'h0000);
    @(negedge ref_clk);
    check(cfg_word, {3'h0, a & 14'h3EFF});
    a = cfg(3'h2, 1'b0, 3'h3, 1'b0, 3'h1);
    ctl.cmd(DDRCM_CMD_LOAD, 3'h0, a);
    @(negedge ref_clk);
    check({test_mode, cfg_word}, {1'b0, 3'h0, a});
  endtask
  task automatic t_wr_rd();
    ctl.cmd(DDRCM_CMD_ACT, 3'h1, 14'h0001);
    ctl.cmd(DDRCM_CMD_WRITE, 3'h1, 14'h0000);
    ctl.wdata(2, 16'hA000, 16'h0000, 4);
    repeat (3) @(posedge ref_clk);
    ctl.cmd(DDRCM_CMD_WRITE, 3'h1, 14'h0001);
    ctl.wdata(2, 16'hB000, 16'h0004, 4);
    repeat (3) @(posedge ref_clk);
    rd(3'h1, 14'h0002, 3, 4, '{16'hB102, 16'hB202, 16'hB303, 16'hB000, 0, 0, 0, 0});
    @(posedge ref_clk);
    additive_lat <= 3'h2;
    rd(3'h1, 14'h0000, 5, 4, '{16'hB303, 16'hB000, 16'hB102, 16'hB202, 0, 0, 0, 0});
    @(posedge ref_clk);
    additive_lat <= 3'h0;
    ctl.clk_en(1'b0);
    repeat (2) @(negedge ref_clk);
    check(dll_frozen, 1'b0);
    ctl.clk_en(1'b1);
  endtask
  task automatic t_pre_ref();
    logic [1:0] r;
    int n;
    ctl.cmd(DDRCM_CMD_PRE, 3'h1, 14'h0000);
    @(negedge ref_clk);
    check(bank_open, 4'h0);
    wait_idle(1);
    rd(3'h1, 14'h0000, 3, 0, '{default: 16'h0000});
    ctl.cmd(DDRCM_CMD_PRE, 3'h1, 14'h0000);
    @(negedge ref_clk);
    @(negedge ref_clk);
    check(bank_idle[1], 1'b0);
    wait_idle(1);
    r = refresh_row;
    ctl.cmd(DDRCM_CMD_REF, 3'h5, 14'h2A55);
    @(negedge ref_clk);
    check(refresh_row, 2'(r + 2'h1));
    ctl.desel(1'b1);
    ctl.cmd(DDRCM_CMD_REF, 3'h0, 14'h0000);
    @(negedge ref_clk);
    check(refresh_row, 2'(r + 2'h1));
    ctl.desel(1'b0);
    ctl.clk_en(1'b0);
    ctl.cmd(DDRCM_CMD_REF, 3'h0, 14'h0000);
    repeat (2) @(negedge ref_clk);
    check({self_refresh, dll_ready}, 2'b10);
    ctl.clk_en(1'b1);
    repeat (3) @(negedge ref_clk);
    check({self_refresh, dll_ready}, 2'b00);
    wait_dll(n);
  endtask
  task automatic t_bl8();
    logic [15:0] e[8];
    ctl.cmd(DDRCM_CMD_LOAD, 3'h0, cfg(3'h3, 1'b1, 3'h4, 1'b0, 3'h5) | 14'h1000);
    ctl.cmd(DDRCM_CMD_ACT, 3'h2, 14'h0002);
    ctl.cmd(DDRCM_CMD_WRITE, 3'h2, 14'h0400);
    ctl.wdata(3, 16'h1000, 16'h0000, 8);
    repeat (5) @(posedge ref_clk);
    @(negedge ref_clk);
    check(bank_open[2], 1'b1);
    @(negedge ref_clk);
    check(bank_open[2], 1'b0);
    wait_idle(2);
    check(bank_open[2], 1'b0);
    ctl.cmd(DDRCM_CMD_ACT, 3'h2, 14'h0002);
    for (int i = 0; i < 8; i++) e[i] = 16'h1000 + 16'(5 ^ i) * 16'h0101;
    rd(3'h2, 14'h0005, 4, 8, e);
    ctl.clk_en(1'b0);
    repeat (2) @(negedge ref_clk);
    check(dll_frozen, 1'b1);
    ctl.clk_en(1'b1);
  endtask
  initial begin
    repeat (5) @(posedge ref_clk);
    resetn <= 1'b1;
    t_config();
    t_wr_rd();
    t_pre_ref();
    t_bl8();
    complete_run();
  end
endmodule
`default_nettype wire
